// ==== rtl/port_power_cfg_pkg.sv ====
// Shared constants for the general configuration register of the port power controller.
package port_power_cfg_pkg;

	// Register map on the register port.
	localparam logic [7:0] GENERAL_CONFIGURATION_ADDR = 8'h15;
	localparam logic [7:0] GENERAL_CONFIGURATION_RST  = 8'h01;

	// Field positions inside the general configuration register.
	localparam int ALERT_MASK_BIT      = 7;
	localparam int UNUSED_BIT          = 6;
	localparam int ALERT_LINK_BIT      = 5;
	localparam int DISCHARGE_BIT       = 4;
	localparam int QUOTA_ENABLE_BIT    = 3;
	localparam int TALLY_CLEAR_BIT     = 2;
	localparam int ACTION_MSB          = 1;
	localparam int ACTION_LSB          = 0;

	// Mask of bits that software can write; the unused bit is held at zero.
	localparam logic [7:0] WRITABLE_MASK = 8'hBF;

	// Encodings of the quota limit action field.
	localparam logic [1:0] ACTION_REPORT            = 2'h0;
	localparam logic [1:0] ACTION_REPORT_DISCONNECT = 2'h1;
	localparam logic [1:0] ACTION_DISCONNECT_SLEEP  = 2'h2;
	localparam logic [1:0] ACTION_IGNORE            = 2'h3;

endpackage : port_power_cfg_pkg

// ==== rtl/quota_response.sv ====
// Quota-reached flag and the response that the quota limit action field selects.
`timescale 1ns/1ps
module quota_response
	import port_power_cfg_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       quota_enable,
	input  wire logic       tally_clear,
	input  wire logic [1:0] quota_limit_action,
	input  wire logic       quota_threshold_hit,
	output logic            charge_quota_reached_flag,
	output logic            quota_report,
	output logic            quota_disconnect,
	output logic            quota_sleep_request
);

	logic flag_set;
	logic flag_clear;

	// A hit counts only while accounting runs and the action is not ignore.
	assign flag_set   = quota_threshold_hit & quota_enable
		& (quota_limit_action != ACTION_IGNORE);
	// Disabling accounting withdraws the flag; a tally clear also restarts it.
	assign flag_clear = ~quota_enable | tally_clear;

	// Set wins over clear so that a hit in the clearing cycle is not lost.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_quota_reached_flag <= 1'b0;
		end else if (flag_set) begin
			charge_quota_reached_flag <= 1'b1;
		end else if (flag_clear) begin
			charge_quota_reached_flag <= 1'b0;
		end
	end

	// Response decode; all of it is gated by enable so disabling removes it at once.
	assign quota_report        = charge_quota_reached_flag & quota_enable
		& ((quota_limit_action == ACTION_REPORT)
		| (quota_limit_action == ACTION_REPORT_DISCONNECT));
	assign quota_disconnect    = charge_quota_reached_flag & quota_enable
		& ((quota_limit_action == ACTION_REPORT_DISCONNECT)
		| (quota_limit_action == ACTION_DISCONNECT_SLEEP));
	assign quota_sleep_request = charge_quota_reached_flag & quota_enable
		& (quota_limit_action == ACTION_DISCONNECT_SLEEP);

	a_ignore_no_flag : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(quota_threshold_hit && quota_limit_action == ACTION_IGNORE
		&& !charge_quota_reached_flag) |=> !charge_quota_reached_flag)
		else $error("Ignore action still raised the quota flag.");

	a_disable_withdraw : assert property (@(posedge ref_clk) disable iff (!rst_n)
		!quota_enable |=> !charge_quota_reached_flag && !quota_report
		&& !quota_disconnect && !quota_sleep_request)
		else $error("Quota response survived disabled accounting.");

endmodule : quota_response

// ==== rtl/port_power_general_config.sv ====
// General configuration register of the port power controller and its control outputs.
`timescale 1ns/1ps
module port_power_general_config
	import port_power_cfg_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	input  wire logic       error_condition,
	input  wire logic       low_current_indicator,
	input  wire logic       thermal_regulation_indicator,
	input  wire logic       quota_threshold_hit,
	output logic            alert_active,
	output logic            switch_open_request,
	output logic            bus_discharge_active,
	output logic            accumulate_enable,
	output logic            charge_tally_zero,
	output logic            charge_quota_reached_flag,
	output logic            quota_report,
	output logic            quota_sleep_request
);

	// Position of the self-clearing tally bit inside the register byte.
	localparam logic [7:0] TALLY_CLEAR_MASK = 8'h01 << TALLY_CLEAR_BIT;

	logic [7:0] general_configuration;
	logic [7:0] next_general_configuration;
	logic       cfg_hit;
	logic       cfg_write;
	logic       enable_falling;
	logic       tally_clear;
	logic       quota_disconnect;
	logic       bus_discharge_request;
	logic       charge_quota_enable;
	logic       alert_link;
	logic       alert_mask;
	logic [1:0] quota_limit_action;

	// Address decode for the single register of this block.
	assign cfg_hit   = (reg_addr == GENERAL_CONFIGURATION_ADDR);
	assign cfg_write = reg_write & cfg_hit;

	// Field views of the stored register.
	assign alert_mask            = general_configuration[ALERT_MASK_BIT];
	assign alert_link            = general_configuration[ALERT_LINK_BIT];
	assign bus_discharge_request = general_configuration[DISCHARGE_BIT];
	assign charge_quota_enable   = general_configuration[QUOTA_ENABLE_BIT];
	assign tally_clear           = general_configuration[TALLY_CLEAR_BIT];
	assign quota_limit_action    = general_configuration[ACTION_MSB:ACTION_LSB];

	// Next value: writes land through the writable mask, and the tally clear bit
	// drops by itself one cycle after it was set so software never sees it stuck.
	assign next_general_configuration = cfg_write
		? (reg_wdata & WRITABLE_MASK)
		: (general_configuration & ~TALLY_CLEAR_MASK);

	// Only the power-on reset touches this register; the Sleep state does not,
	// so contents survive Sleep without any extra retention logic.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			general_configuration <= GENERAL_CONFIGURATION_RST;
		end else begin
			general_configuration <= next_general_configuration;
		end
	end

	// Read data is registered; other addresses return zero.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= cfg_hit ? general_configuration : 8'h00;
		end
	end

	// A one-to-zero write of the enable is seen as the stored bit falling.
	assign enable_falling = cfg_write & charge_quota_enable
		& ~reg_wdata[QUOTA_ENABLE_BIT];

	// Tally zero pulse to the charge datapath, one cycle wide per event.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_tally_zero <= 1'b0;
		end else begin
			charge_tally_zero <= enable_falling
				| (cfg_write & reg_wdata[TALLY_CLEAR_BIT]);
		end
	end

	// Accumulation runs only with the enable set.
	assign accumulate_enable = charge_quota_enable;

	// The switch opens for discharge or a quota disconnect; discharge has no
	// timeout, so software must clear the bit to let the switch close again.
	assign switch_open_request  = bus_discharge_request | quota_disconnect;
	assign bus_discharge_active = bus_discharge_request;

	// Alert: errors unless masked, indicators only when linked.
	assign alert_active = (error_condition & ~alert_mask)
		| (alert_link & (low_current_indicator | thermal_regulation_indicator));

	// Quota flag and action response.
	quota_response u_quota_response (
		.ref_clk                   (ref_clk),
		.rst_n                     (rst_n),
		.quota_enable              (charge_quota_enable),
		.tally_clear               (tally_clear),
		.quota_limit_action        (quota_limit_action),
		.quota_threshold_hit       (quota_threshold_hit),
		.charge_quota_reached_flag (charge_quota_reached_flag),
		.quota_report              (quota_report),
		.quota_disconnect          (quota_disconnect),
		.quota_sleep_request       (quota_sleep_request)
	);

	// Register port: writes land through the mask and reads return the stored byte.
	a_write_lands : assert property (@(posedge ref_clk) disable iff (!rst_n)
		cfg_write |=> general_configuration == ($past(reg_wdata) & WRITABLE_MASK))
		else $error("Register write did not land through the mask.");

	a_read_data : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_read && cfg_hit) |=> reg_rdata == $past(general_configuration))
		else $error("Read data does not match the stored register.");

	a_read_foreign : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_read && !cfg_hit) |=> reg_rdata == 8'h00)
		else $error("Read of a foreign address returned data.");

	a_unused_zero : assert property (@(posedge ref_clk) disable iff (!rst_n)
		!general_configuration[UNUSED_BIT] && !reg_rdata[UNUSED_BIT])
		else $error("Unused bit not zero.");

	a_hold_no_write : assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cfg_write |=> (general_configuration & ~TALLY_CLEAR_MASK)
		== ($past(general_configuration) & ~TALLY_CLEAR_MASK))
		else $error("Register changed without a write.");

	// Discharge: the switch opens and holds with the request bit; clearing it drops bus_discharge_active.
	a_discharge_opens : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cfg_write && reg_wdata[DISCHARGE_BIT]) |=> switch_open_request && bus_discharge_active)
		else $error("Discharge write did not open switch.");

	a_discharge_holds : assert property (@(posedge ref_clk) disable iff (!rst_n)
		bus_discharge_request && !cfg_write |=> switch_open_request)
		else $error("Switch closed while discharge still requested.");

	a_discharge_release : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cfg_write && !reg_wdata[DISCHARGE_BIT]) |=> !bus_discharge_active)
		else $error("Discharge stayed active after the request was cleared.");

	// Accounting: enable, tally zeroing and the self-clearing tally bit.
	a_disable_zeroes : assert property (@(posedge ref_clk) disable iff (!rst_n)
		enable_falling |=> charge_tally_zero && !accumulate_enable)
		else $error("Disabling accounting did not zero tally.");

	a_no_accumulate : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cfg_write && !reg_wdata[QUOTA_ENABLE_BIT]) |=> !accumulate_enable)
		else $error("Accumulating while disabled.");

	a_disable_flag_clear : assert property (@(posedge ref_clk) disable iff (!rst_n)
		enable_falling |=> ##1 !charge_quota_reached_flag)
		else $error("Quota flag survived disabling.");

	a_tally_selfclear : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cfg_write && reg_wdata[TALLY_CLEAR_BIT]) |=> charge_tally_zero && tally_clear
		##1 (!tally_clear || $past(cfg_write)))
		else $error("Tally clear bit did not self-clear.");

	a_selfclear_idle : assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cfg_write |=> !tally_clear)
		else $error("Tally clear bit stayed set without a write.");

	a_tally_only_write : assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cfg_write |=> !charge_tally_zero)
		else $error("Tally zero pulse without a register write.");

	a_tally_clear_flag : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tally_clear && !quota_threshold_hit) |=> !charge_quota_reached_flag)
		else $error("Tally clear did not drop the quota flag.");

	// Threshold action: each of the three acting codes drives its own set of responses.
	a_sleep_action : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(charge_quota_reached_flag && charge_quota_enable
		&& quota_limit_action == ACTION_DISCONNECT_SLEEP)
		|-> quota_sleep_request && switch_open_request && !quota_report)
		else $error("Disconnect and sleep action wrong.");

	a_disconnect_action : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(charge_quota_reached_flag && charge_quota_enable
		&& quota_limit_action == ACTION_REPORT_DISCONNECT)
		|-> quota_report && switch_open_request && !quota_sleep_request)
		else $error("Report and disconnect action wrong.");

	a_report_only : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(charge_quota_reached_flag && charge_quota_enable && !bus_discharge_request
		&& quota_limit_action == ACTION_REPORT)
		|-> quota_report && !switch_open_request && !quota_sleep_request)
		else $error("Report-only action opened the switch or asked for sleep.");

	// Alert: indicator path through the link bit, error path through the mask.
	a_link_alert : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(alert_link && (low_current_indicator || thermal_regulation_indicator)) |-> alert_active)
		else $error("Linked indicator did not raise alert.");

	a_unlinked_quiet : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!alert_link && !error_condition) |-> !alert_active)
		else $error("Alert raised by an unlinked indicator.");

	a_mask_alert : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(error_condition && !alert_link) |-> (alert_active == !alert_mask))
		else $error("Alert mask not honoured.");

	a_alert_quiet : assert property (@(posedge ref_clk) disable iff (!rst_n)
		(alert_mask && !alert_link) |-> !alert_active)
		else $error("Masked error still raised the alert.");

endmodule : port_power_general_config

// ==== verif/reg_host.sv ====
// Host model that drives the register port of the general configuration block.
`timescale 1ns/1ps
module reg_host (
	input  wire logic       ref_clk,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_write,
	output logic            reg_read,
	input  wire logic [7:0] reg_rdata
);
	// Strobes idle low from time zero.
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// Released lines show the inverse so that a stale value can never pass as fresh.
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#2;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge ref_clk);
		#2;
		reg_write = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr

	// Read data is registered, so it is taken one edge after the strobe.
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#2;
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge ref_clk);
		#2;
		reg_read = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask : rd
endmodule : reg_host

// ==== verif/port_power_general_config_tb.sv ====
// Self-checking testbench for the general configuration register block.
`timescale 1ns/1ps
module port_power_general_config_tb import port_power_cfg_pkg::*;;
	logic       ref_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       error_condition = 1'b0;
	logic       low_current_indicator = 1'b0;
	logic       thermal_regulation_indicator = 1'b0;
	logic       quota_threshold_hit = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
	logic       reg_write, reg_read, alert_active, switch_open_request, bus_discharge_active;
	logic       accumulate_enable, charge_tally_zero, charge_quota_reached_flag;
	logic       quota_report, quota_sleep_request;
	logic [1:0] a;
	int         n_errors = 0;
	int         n_checks = 0;
	int         cycles = 0;

	// The clock toggles every 12.5 ns, half of its 25 ns period.
	always #12.5 ref_clk = ~ref_clk;

	reg_host i_host (.ref_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
	port_power_general_config i_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .error_condition, .low_current_indicator,
		.thermal_regulation_indicator, .quota_threshold_hit, .alert_active,
		.switch_open_request, .bus_discharge_active, .accumulate_enable, .charge_tally_zero,
		.charge_quota_reached_flag, .quota_report, .quota_sleep_request);

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task finish_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// The whole run needs about a hundred cycles; a hang is cut off well beyond that.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			finish_test();
		end
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		#2;
		rst_n = 1'b1;
		i_host.rd(GENERAL_CONFIGURATION_ADDR, rdv);
		chk(rdv, GENERAL_CONFIGURATION_RST);
		chk({7'h0, switch_open_request}, 8'h00);
		i_host.wr(8'h15, 8'h5C);
		chk({4'h0, switch_open_request, bus_discharge_active, accumulate_enable,
			charge_tally_zero}, 8'h0F);
		i_host.wr(8'h16, 8'h00);
		chk({6'h0, switch_open_request, charge_tally_zero}, 8'h02);
		i_host.rd(8'h16, rdv);
		chk(rdv, 8'h00);
		i_host.rd(8'h15, rdv);
		chk(rdv, 8'h18);
		i_host.wr(8'h15, 8'h10);
		chk({6'h0, accumulate_enable, charge_tally_zero}, 8'h01);
		i_host.wr(8'h15, 8'h00);
		chk({7'h0, switch_open_request}, 8'h00);
		// Every action code sees one threshold hit, then accounting is switched off.
		for (int i = 0; i < 4; i++) begin
			a = i[1:0];
			i_host.wr(8'h15, {6'h02, a});
			@(posedge ref_clk);
			#2;
			quota_threshold_hit = 1'b1;
			@(posedge ref_clk);
			#2;
			quota_threshold_hit = 1'b0;
			chk({4'h0, charge_quota_reached_flag, quota_report, switch_open_request,
				quota_sleep_request}, {4'h0, a != ACTION_IGNORE,
				a == ACTION_REPORT || a == ACTION_REPORT_DISCONNECT,
				a == ACTION_REPORT_DISCONNECT || a == ACTION_DISCONNECT_SLEEP,
				a == ACTION_DISCONNECT_SLEEP});
			i_host.rd(8'h15, rdv);
			chk(rdv, {6'h02, a});
			i_host.wr(8'h15, {6'h00, a});
			chk({5'h0, quota_report, switch_open_request, quota_sleep_request}, 8'h00);
			@(posedge ref_clk);
			#2;
			chk({7'h0, charge_quota_reached_flag}, 8'h00);
		end
		// A tally clear with accounting left on drops a reached flag by itself.
		i_host.wr(8'h15, 8'h08);
		@(posedge ref_clk);
		#2;
		quota_threshold_hit = 1'b1;
		@(posedge ref_clk);
		#2;
		quota_threshold_hit = 1'b0;
		chk({7'h0, charge_quota_reached_flag}, 8'h01);
		i_host.wr(8'h15, 8'h0C);
		chk({6'h0, charge_tally_zero, accumulate_enable}, 8'h03);
		@(posedge ref_clk);
		#2;
		chk({6'h0, charge_quota_reached_flag, quota_report}, 8'h00);
		i_host.rd(8'h15, rdv);
		chk(rdv, 8'h08);
		// Alert truth table over mask, link and the three event inputs.
		for (int j = 0; j < 32; j++) begin
			if (j % 8 == 0)
				i_host.wr(8'h15, {j[4], 1'b0, j[3], 5'h00});
			@(posedge ref_clk);
			#2;
			error_condition = j[0];
			low_current_indicator = j[1];
			thermal_regulation_indicator = j[2];
			#1;
			chk({7'h0, alert_active},
				{7'h0, (j[0] && !j[4]) || (j[3] && (j[1] || j[2]))});
		end
		finish_test();
	end
endmodule : port_power_general_config_tb
